//--- rtl/async_rx_consts.svh
// constants of the asynchronous serial receiver
// assumes inclusion by the package and the design modules of this block
`ifndef ASYNC_RX_CONSTS_SVH
`define ASYNC_RX_CONSTS_SVH

// bit rate ratio field codes
`define RATIO_X1 2'h0
`define RATIO_X16 2'h1
`define RATIO_X32 2'h2
`define RATIO_X64 2'h3

// receive clock edges per bit for each ratio
`define TICKS_X1 7'h01
`define TICKS_X16 7'h10
`define TICKS_X32 7'h20
`define TICKS_X64 7'h40

// character length field codes
`define CHAR_LEN_8 2'h0
`define CHAR_LEN_7 2'h1
`define CHAR_LEN_6 2'h2
`define CHAR_LEN_5 2'h3

// parity / marker select codes
`define PAR_NONE 2'h0
`define PAR_MARKER 2'h1
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3

// reset values and buffer full count
`define FLAGS_RESET 5'h00
`define HIST_RESET 2'h3
`define BUF_COUNT_FULL 2'h2

`endif

//--- rtl/async_rx_pkg.sv
// types shared by the asynchronous serial receiver and its character buffer
// assumes async_rx_consts.svh is on the include path
`include "async_rx_consts.svh"

package async_rx_pkg;

    typedef enum logic [2:0] {
        st_disabled,
        st_search,
        st_start_check,
        st_assemble,
        st_half_wait,
        st_break_wait,
        st_break_check
    } rx_state_e;

    // one received character with its status
    typedef struct packed {
        logic address_marker_bit;
        logic overrun_err;
        logic framing_err;
        logic parity_err;
        logic [7:0] data;
    } rx_char_s;

    // sticky fault flags, also used for clear strobes and interrupt enables
    typedef struct packed {
        logic break_end_flag;
        logic break_start_flag;
        logic overrun_fault_flag;
        logic framing_fault_flag;
        logic parity_fault_flag;
    } fault_flags_s;

    typedef struct packed {
        rx_state_e state;
        logic [6:0] cnt;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic pbit;
        logic [1:0] hist;
        fault_flags_s flags;
        logic head_flagged;
        logic irq;
        logic enabled;
    } rx_regs_s;

    typedef struct packed {
        rx_char_s head;
        rx_char_s tail;
        logic [1:0] count;
        logic valid;
    } buf_regs_s;

endpackage

//--- rtl/rx_char_buffer.sv
// two-entry character buffer; a write while full overwrites the bottom entry
// assumes the writer treats in_ready_o low as an overrun of the bottom stage
`timescale 1ns/1ps
`include "async_rx_consts.svh"

module rx_char_buffer (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // write side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input async_rx_pkg::rx_char_s in_data_i,
    // read side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output async_rx_pkg::rx_char_s out_data_o
);

    async_rx_pkg::buf_regs_s s;
    async_rx_pkg::buf_regs_s next_s;

    // a pop in the same cycle frees a place, so that write is no overrun
    assign in_ready_o = (s.count != `BUF_COUNT_FULL) | out_ready_i;
    assign out_valid_o = s.valid;
    assign out_data_o = s.head;

    always_comb begin
        next_s = s;
        if (s.valid && out_ready_i) begin
            next_s.head = s.tail;
            next_s.count = s.count - 2'h1;
        end
        if (in_valid_i) begin
            if (next_s.count == 2'h0) begin
                next_s.head = in_data_i;
                next_s.count = 2'h1;
            end else if (next_s.count == 2'h1) begin
                next_s.tail = in_data_i;
                next_s.count = 2'h2;
            end else begin
                next_s.tail = in_data_i;
            end
        end
        next_s.valid = (next_s.count != 2'h0);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

//--- rtl/async_serial_receiver.sv
// asynchronous-mode receiver of one serial channel with sticky fault flags
// assumes rx_clk_tick_i marks each rising receive clock edge and rxd_i is synchronous to clk_i
//
// Behaviour
// (R01) reception begins, in start search, only after an enable command
// (R02) break end high: wait half bit, resample; high ends, low returns to wait
// (R03) single-sample ratio: first high at break end goes straight to start search
// (R04) single-sample ratio: low seen on an edge, assembly starts next edge
// (R05) shift data bits, then parity/marker bit, then stop bit; store in buffer
// (R06) single-sample ratio: start search resumes one cycle after a character
// (R07) oversampled: recheck low half bit later; low starts assembly, high is noise
// (R08) oversampled: stop checked one bit after last bit; low adds half-bit wait
// (R09) oversampled: each sample is majority of current and two previous samples
// (R10) five to eight data bits chosen by field; unused high bits read zero
// (R11) even parity: error when total ones of data and parity bit is odd
// (R12) odd parity: error when total ones of data and parity bit is even
// (R13) parity flag set when bad character becomes readable; character still stored
// (R14) low stop sets framing flag when readable; only first stop bit checked
// (R15) framing error does not stop reception; single-sample resumes next cycle
// (R16) arrival with full buffer overwrites bottom stage and marks it overrun
// (R17) overrun flag set when overwriting character becomes readable; reception continues
// (R18) flags stay set until written one or status reset
// (R19) setting an enabled flag raises the interrupt request
// (R20) marker select puts an address-marker bit in the parity bit position
// (R21) all-zero character with framing error is break start: flag set, discarded
// (R22) after break start, half-bit high sets break end; single-sample first high
// (R23) bit rate is receive clock divided by 1, 16, 32 or 64
// (R24) parity covers only the configured number of data bits
// (R25) each buffer entry carries its character and its status together
`timescale 1ns/1ps
`include "async_rx_consts.svh"

module async_serial_receiver (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // receive line and receive clock edge enable
    input wire logic rxd_i,
    input wire logic rx_clk_tick_i,
    // commands, one-cycle pulses
    input wire logic rx_enable_cmd_i,
    input wire logic rx_disable_cmd_i,
    // configuration
    input wire logic [1:0] bit_rate_ratio_field_i,
    input wire logic [1:0] rx_char_length_field_i,
    input wire logic [1:0] parity_marker_select_i,
    // flag control
    input async_rx_pkg::fault_flags_s flag_clear_i,
    input wire logic status_reset_i,
    input async_rx_pkg::fault_flags_s irq_enable_i,
    // received characters
    output logic char_valid_o,
    input wire logic char_ready_i,
    output async_rx_pkg::rx_char_s char_o,
    // status
    output async_rx_pkg::fault_flags_s fault_flags_o,
    output logic rx_enabled_o,
    output logic irq_o
);

    async_rx_pkg::rx_regs_s s;
    async_rx_pkg::rx_regs_s next_s;
    async_rx_pkg::rx_char_s push_data;
    logic push;
    logic buf_in_ready;
    logic ratio_one;
    logic level;
    logic [6:0] bit_ticks;
    logic [6:0] half_ticks;
    logic [3:0] char_len;
    logic has_pbit;
    logic [7:0] aligned;
    logic is_stop;

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [6:0] ticks_per_bit(input logic [1:0] ratio);
        unique case (ratio)
            `RATIO_X1: ticks_per_bit = `TICKS_X1;
            `RATIO_X16: ticks_per_bit = `TICKS_X16;
            `RATIO_X32: ticks_per_bit = `TICKS_X32;
            `RATIO_X64: ticks_per_bit = `TICKS_X64;
        endcase
    endfunction

    function automatic logic [3:0] len_of(input logic [1:0] code);
        len_of = 4'h8 - {2'h0, code};
    endfunction

    function automatic logic [7:0] len_mask(input logic [3:0] len);
        len_mask = 8'hff >> (4'h8 - len);
    endfunction

    rx_char_buffer char_buffer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(push),
        .in_ready_o(buf_in_ready),
        .in_data_i(push_data), // R25
        .out_valid_o(char_valid_o),
        .out_ready_i(char_ready_i),
        .out_data_o(char_o)
    );

    assign ratio_one = (bit_rate_ratio_field_i == `RATIO_X1);
    assign bit_ticks = ticks_per_bit(bit_rate_ratio_field_i); // R23
    assign half_ticks = bit_ticks >> 1;
    // single-sample takes the raw line, oversampled takes the 2-of-3 vote
    assign level = ratio_one ? rxd_i : majority(s.hist[1], s.hist[0], rxd_i); // R09
    assign char_len = len_of(rx_char_length_field_i); // R10
    assign has_pbit = (parity_marker_select_i != `PAR_NONE);
    assign aligned = s.shreg >> (4'h8 - char_len); // R10
    assign is_stop = (s.bits == char_len + {3'h0, has_pbit});

    // stop sample: build the character and its status
    always_comb begin
        push_data.data = aligned & len_mask(char_len); // R10
        push_data.framing_err = !level; // R14
        push_data.overrun_err = !buf_in_ready; // R16
        push_data.address_marker_bit = (parity_marker_select_i == `PAR_MARKER) & s.pbit; // R20
        unique case (parity_marker_select_i)
            `PAR_EVEN: push_data.parity_err = ^{aligned & len_mask(char_len), s.pbit}; // R11 R24
            `PAR_ODD: push_data.parity_err = ~^{aligned & len_mask(char_len), s.pbit}; // R12 R24
            default: push_data.parity_err = 1'b0;
        endcase
    end

    // break start: null data and parity with framing error is not stored
    assign push = (s.state == async_rx_pkg::st_assemble) && rx_clk_tick_i && (s.cnt == 7'h0) && is_stop
        && !(!level && (push_data.data == 8'h00) && !s.pbit); // R05 R21

    always_comb begin
        next_s = s;
        // flags collect only this cycle's set events until the merge below
        next_s.flags = `FLAGS_RESET;
        if (rx_clk_tick_i) begin
            next_s.hist = {s.hist[0], rxd_i};
        end
        unique case (s.state)
            async_rx_pkg::st_disabled: begin
                if (rx_enable_cmd_i) begin
                    next_s.state = async_rx_pkg::st_search; // R01
                end
            end
            async_rx_pkg::st_search: begin
                if (rx_clk_tick_i && !level) begin
                    next_s.bits = 4'h0;
                    next_s.pbit = 1'b0;
                    if (ratio_one) begin
                        next_s.state = async_rx_pkg::st_assemble; // R04
                        next_s.cnt = 7'h0;
                    end else begin
                        next_s.state = async_rx_pkg::st_start_check; // R07
                        next_s.cnt = half_ticks - 7'h1;
                    end
                end
            end
            async_rx_pkg::st_start_check: begin
                if (rx_clk_tick_i) begin
                    if (s.cnt != 7'h0) begin
                        next_s.cnt = s.cnt - 7'h1;
                    end else if (!level) begin
                        next_s.state = async_rx_pkg::st_assemble; // R07
                        next_s.cnt = bit_ticks - 7'h1;
                    end else begin
                        next_s.state = async_rx_pkg::st_search; // R07
                    end
                end
            end
            async_rx_pkg::st_assemble: begin
                if (rx_clk_tick_i) begin
                    if (s.cnt != 7'h0) begin
                        next_s.cnt = s.cnt - 7'h1;
                    end else if (is_stop) begin
                        if (!level && (push_data.data == 8'h00) && !s.pbit) begin
                            next_s.state = async_rx_pkg::st_break_wait; // R21
                            next_s.flags.break_start_flag = 1'b1; // R21
                        end else if (!level && !ratio_one) begin
                            next_s.state = async_rx_pkg::st_half_wait; // R08 R15
                            next_s.cnt = half_ticks - 7'h1;
                        end else begin
                            next_s.state = async_rx_pkg::st_search; // R06 R08 R15
                        end
                    end else begin
                        next_s.cnt = bit_ticks - 7'h1;
                        next_s.bits = s.bits + 4'h1;
                        if (s.bits < char_len) begin
                            next_s.shreg = {level, s.shreg[7:1]}; // R05
                        end else begin
                            next_s.pbit = level; // R05 R20
                        end
                    end
                end
            end
            async_rx_pkg::st_half_wait: begin
                if (rx_clk_tick_i) begin
                    if (s.cnt != 7'h0) begin
                        next_s.cnt = s.cnt - 7'h1;
                    end else begin
                        next_s.state = async_rx_pkg::st_search; // R08
                    end
                end
            end
            async_rx_pkg::st_break_wait: begin
                if (rx_clk_tick_i && level) begin
                    if (ratio_one) begin
                        next_s.state = async_rx_pkg::st_search; // R03
                        next_s.flags.break_end_flag = 1'b1; // R22
                    end else begin
                        next_s.state = async_rx_pkg::st_break_check; // R02
                        next_s.cnt = half_ticks - 7'h1;
                    end
                end
            end
            async_rx_pkg::st_break_check: begin
                if (rx_clk_tick_i) begin
                    if (s.cnt != 7'h0) begin
                        next_s.cnt = s.cnt - 7'h1;
                    end else if (level) begin
                        next_s.state = async_rx_pkg::st_search; // R02
                        next_s.flags.break_end_flag = 1'b1; // R22
                    end else begin
                        next_s.state = async_rx_pkg::st_break_wait; // R02
                    end
                end
            end
            default: begin
                next_s.state = async_rx_pkg::st_disabled;
            end
        endcase
        if (rx_disable_cmd_i) begin
            next_s.state = async_rx_pkg::st_disabled;
        end
        // head status joins the flags once, when the character becomes readable
        if (char_valid_o && !s.head_flagged) begin
            next_s.flags.parity_fault_flag = next_s.flags.parity_fault_flag | char_o.parity_err; // R13
            next_s.flags.framing_fault_flag = next_s.flags.framing_fault_flag | char_o.framing_err; // R14
            next_s.flags.overrun_fault_flag = next_s.flags.overrun_fault_flag | char_o.overrun_err; // R17
        end
        next_s.head_flagged = char_valid_o && !char_ready_i;
        // a clear loses against a set arriving in the same cycle
        next_s.flags = (s.flags & ~flag_clear_i) | next_s.flags; // R18
        if (status_reset_i) begin
            next_s.flags = `FLAGS_RESET; // R18
        end
        next_s.enabled = (next_s.state != async_rx_pkg::st_disabled);
        next_s.irq = |(next_s.flags & irq_enable_i); // R19
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s <= '0;
            s.state <= async_rx_pkg::st_disabled;
            s.hist <= `HIST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign fault_flags_o = s.flags;
    assign rx_enabled_o = s.enabled;
    assign irq_o = s.irq;

    sequence low_seen_1x;
        (s.state == async_rx_pkg::st_search) && rx_clk_tick_i && ratio_one && !level && !rx_disable_cmd_i;
    endsequence

    sequence high_seen_break_1x;
        (s.state == async_rx_pkg::st_break_wait) && rx_clk_tick_i && ratio_one && level && !rx_disable_cmd_i
        && !status_reset_i;
    endsequence

    enable_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R01
        (s.state == async_rx_pkg::st_disabled) && !rx_enable_cmd_i |=> (s.state == async_rx_pkg::st_disabled))
        else $error("receiver left disabled state without enable");
    start_single_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R04
        low_seen_1x |=> (s.state == async_rx_pkg::st_assemble) && (s.cnt == 7'h0))
        else $error("single-sample start did not enter assembly");
    break_single_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R03
        high_seen_break_1x |=> (s.state == async_rx_pkg::st_search) && s.flags.break_end_flag)
        else $error("single-sample break end not taken at first high");
    noise_reject_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R07
        (s.state == async_rx_pkg::st_start_check) && rx_clk_tick_i && (s.cnt == 7'h0) && level && !rx_disable_cmd_i
        |=> (s.state == async_rx_pkg::st_search))
        else $error("noise low did not return to search");
    char_fill_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
        push |-> ((push_data.data >> char_len) == 8'h00))
        else $error("unused high bits of character not zero");
    even_parity_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
        push && (parity_marker_select_i == `PAR_EVEN) |-> (push_data.parity_err == ^{push_data.data, s.pbit}))
        else $error("even parity check wrong");
    overrun_mark_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
        push && !buf_in_ready |-> push_data.overrun_err ##1 char_valid_o && $stable(char_o))
        else $error("overwrite of full buffer not marked or head disturbed");
    break_discard_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R21
        (s.state == async_rx_pkg::st_assemble) && rx_clk_tick_i && (s.cnt == 7'h0) && is_stop && !level
        && (aligned == 8'h00) && !s.pbit |-> !push)
        else $error("break start character was stored");
    flag_sticky_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
        s.flags.parity_fault_flag && !flag_clear_i.parity_fault_flag && !status_reset_i |=> s.flags.parity_fault_flag)
        else $error("parity flag dropped without clear");
    irq_raise_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R19
        s.flags.framing_fault_flag && irq_enable_i.framing_fault_flag && !status_reset_i
        && !flag_clear_i.framing_fault_flag |=> irq_o)
        else $error("enabled framing flag raised no interrupt");

endmodule

//--- sim/async_tx_model.sv
// behavioural remote asynchronous transmitter driving the receive line
// assumes tick_i marks each receive clock edge and go_i is a one-cycle pulse given while idle
`timescale 1ns/1ps

module async_tx_model (
    // clock, reset and receive clock edge enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    // frame request: bits sent lsb first, each held tpb_i ticks
    input wire logic go_i,
    input wire logic [31:0] frame_i,
    input wire logic [5:0] nbits_i,
    input wire logic [6:0] tpb_i,
    // line and status
    output logic rxd_o,
    output logic busy_o
);
    logic [31:0] sh;
    logic [5:0] left;
    logic [6:0] cnt;

    // line rests at mark between frames
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rxd_o <= 1'b1;
            busy_o <= 1'b0;
            left <= 6'h00;
            cnt <= 7'h00;
            sh <= 32'hffff_ffff;
        end else if (go_i && !busy_o) begin
            sh <= frame_i;
            left <= nbits_i;
            cnt <= 7'h00;
            busy_o <= 1'b1;
        end else if (busy_o && tick_i) begin
            if (cnt != 7'h00) begin
                cnt <= cnt - 7'h01;
            end else if (left == 6'h00) begin
                rxd_o <= 1'b1;
                busy_o <= 1'b0;
            end else begin
                rxd_o <= sh[0];
                sh <= sh >> 1;
                left <= left - 6'h01;
                cnt <= tpb_i - 7'h01;
            end
        end
    end
endmodule

//--- sim/testbench.sv
// self-checking bench for the asynchronous serial receiver
// assumes the design files and the transmitter model are compiled first
`timescale 1ns/1ps
`include "async_rx_consts.svh"

module testbench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic tick = 1'b0;
    logic en_cmd = 1'b0;
    logic [1:0] ratio = `RATIO_X1;
    logic [1:0] len = `CHAR_LEN_8;
    logic [1:0] par = `PAR_NONE;
    async_rx_pkg::fault_flags_s clr = '0;
    async_rx_pkg::fault_flags_s irq_en = '1;
    logic st_rst = 1'b0;
    logic ready = 1'b0;
    logic go = 1'b0;
    logic [31:0] frame = 32'hffff_ffff;
    logic [5:0] nbits = 6'h00;
    logic [6:0] tpb = 7'h01;
    logic rxd, busy, valid, rx_en, irq;
    async_rx_pkg::rx_char_s ch;
    async_rx_pkg::fault_flags_s flags;
    int fails = 0;
    int n_tests = 0;
    int seed = 16;

    async_serial_receiver i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rxd_i(rxd), .rx_clk_tick_i(tick),
        .rx_enable_cmd_i(en_cmd), .rx_disable_cmd_i(1'b0), .bit_rate_ratio_field_i(ratio),
        .rx_char_length_field_i(len), .parity_marker_select_i(par), .flag_clear_i(clr),
        .status_reset_i(st_rst), .irq_enable_i(irq_en), .char_valid_o(valid), .char_ready_i(ready),
        .char_o(ch), .fault_flags_o(flags), .rx_enabled_o(rx_en), .irq_o(irq));
    async_tx_model i_tx (.clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick), .go_i(go), .frame_i(frame),
        .nbits_i(nbits), .tpb_i(tpb), .rxd_o(rxd), .busy_o(busy));

    initial forever #12.5 clk_i = ~clk_i;
    // receive clock edge on every other system clock
    always @(posedge clk_i) tick <= #2 ~tick;

    function automatic logic [6:0] ticks(input logic [1:0] r);
        case (r)
            `RATIO_X1: return `TICKS_X1;
            `RATIO_X16: return `TICKS_X16;
            `RATIO_X32: return `TICKS_X32;
            default: return `TICKS_X64;
        endcase
    endfunction

    function automatic logic pbit(input logic [7:0] dm, input logic marker);
        case (par)
            `PAR_MARKER: return marker;
            `PAR_EVEN: return ^dm;
            default: return ~^dm;
        endcase
    endfunction

    // start, data lsb first, optional parity or marker, one stop bit
    function automatic logic [31:0] mk(input logic [7:0] d, input logic pb, input logic stop, output logic [5:0] n);
        logic [31:0] f;
        int p;
        f = 32'hffff_fffe;
        p = 1;
        for (int i = 0; i < 8 - len; i++) begin
            f[p] = d[i];
            p++;
        end
        if (par != `PAR_NONE) begin
            f[p] = pb;
            p++;
        end
        f[p] = stop;
        n = 6'(p + 1);
        return f;
    endfunction

    task automatic check(input string w, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic tick_wait(input int c);
        repeat (c) @(posedge clk_i);
        #2;
    endtask

    task automatic send(input logic [31:0] f, input logic [5:0] n, input logic [6:0] t);
        int k;
        frame = f;
        nbits = n;
        tpb = t;
        go = 1'b1;
        tick_wait(1);
        go = 1'b0;
        k = 0;
        while (busy && k < 20000) begin
            tick_wait(1);
            k++;
        end
        if (busy) fails++;
        tick_wait(40);
    endtask

    task automatic take(input string w, input logic [11:0] e);
        check(w, {11'h000, valid}, 12'h001);
        check(w, ch, e);
        ready = 1'b1;
        tick_wait(1);
        ready = 1'b0;
        tick_wait(1);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        close_out;
    end

    initial begin
        logic [7:0] d;
        logic [7:0] dm;
        logic [5:0] n;
        logic [31:0] f;
        logic marker;
        logic fl;
        logic pe_acc;
        tick_wait(5);
        reset_n_i = 1'b1;
        f = mk(8'h5a, 1'b0, 1'b1, n);
        send(f, n, 7'h01);
        check("idle valid", {11'h000, valid}, 12'h000);
        en_cmd = 1'b1;
        tick_wait(1);
        en_cmd = 1'b0;
        tick_wait(1);
        check("enabled", {11'h000, rx_en}, 12'h001);
        pe_acc = 1'b0;
        for (int i = 0; i < 64; i++) begin
            ratio = 2'(i >> 4);
            len = 2'(i >> 2);
            par = 2'(i);
            d = 8'($random(seed));
            {marker, fl} = 2'($random(seed));
            fl = fl & par[1];
            dm = d & (8'hff >> len);
            f = mk(d, pbit(dm, marker) ^ fl, 1'b1, n);
            send(f, n, ticks(ratio));
            pe_acc = pe_acc | fl;
            take("char", {par == `PAR_MARKER && marker, 2'b00, fl, dm});
            check("pe flag", {7'h00, flags}, {11'h000, pe_acc});
            check("irq", {11'h000, irq}, {11'h000, pe_acc});
        end
        irq_en = '0;
        tick_wait(2);
        check("irq off", {11'h000, irq}, 12'h000);
        irq_en = '1;
        clr = '1;
        tick_wait(1);
        clr = '0;
        tick_wait(1);
        check("cleared", {7'h00, flags}, 12'h000);
        len = `CHAR_LEN_8;
        par = `PAR_NONE;
        for (int r = 0; r < 2; r++) begin
            ratio = 2'(r);
            f = mk(8'ha5, 1'b0, 1'b0, n);
            send(f, n, ticks(ratio));
            f = mk(8'h3c, 1'b0, 1'b1, n);
            send(f, n, ticks(ratio));
            take("fe char", 12'h2a5);
            take("after fe", 12'h03c);
            check("fe flag", {7'h00, flags}, 12'h002);
        end
        ratio = `RATIO_X1;
        for (int j = 1; j < 4; j++) begin
            f = mk(8'(j), 1'b0, 1'b1, n);
            send(f, n, 7'h01);
        end
        check("overrun_fault_flag early", {7'h00, flags}, 12'h002);
        take("first", 12'h001);
        take("bottom", 12'h403);
        check("overrun_fault_flag flag", {7'h00, flags}, 12'h006);
        ratio = `RATIO_X16;
        send(32'hffff_fffe, 6'h01, 7'h04);
        check("noise", {11'h000, valid}, 12'h000);
        send(32'hc000_0000, 6'h1e, `TICKS_X16);
        check("break kept", {11'h000, valid}, 12'h000);
        check("break flags", {7'h00, flags}, 12'h01e);
        st_rst = 1'b1;
        tick_wait(1);
        st_rst = 1'b0;
        tick_wait(1);
        check("status reset", {7'h00, flags}, 12'h000);
        f = mk(8'h81, 1'b0, 1'b1, n);
        send(f, n, `TICKS_X16);
        take("after break", 12'h081);
        close_out;
    end
endmodule
